// >>> logic/sepc_counters.sv
`timescale 1ns/1ps
// Functional notes
// - Alarm mask resets to ones; upper five bits read one, ignore writes.
// - Optical mask set: pin only mirrored into cause bit, no signal loss.
// - Optical mask clear: high pin declares signal loss, also mirrored.
// - Line RDI mask set blocks automatic Line RDI; clear sends it.
// - Path RDI mask set blocks automatic Path RDI; clear sends it.
// - Section parity hold is 16 bits, read low byte then high byte.
// - Path parity hold is 16 bits, read low byte then high byte.
// - Path REI hold is 16 bits, read in two accesses, low first.
// - Two-part window pointer starts zero, toggles on each window read.
// - Line parity hold is 20 bits, read low, middle, top four bits.
// - Line REI hold is 20 bits, read low, middle, top four bits.
// - Three-part pointer starts 00, steps 00, 01, 10, back to 00.
// - Writing sample trigger copies every live counter into its hold.
// - Hold keeps captured value until the next sample command.
// - Live counter returns to zero when sampled.
// - Writing one to a clear bit zeroes that live counter.
// - Counter reaching all ones sets its overflow flag.
// - Any overflow sets shared overflow cause, raising interrupt request.
// - Counter keeps counting after overflow.
// - Overflow request masked by primary mask bit, which resets to one.
module sepc_counters
  import sepc_pkg::*;
#(
  parameter int SHORT_W = 16,
  parameter int LONG_W  = 20
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Error and REI events, one pulse per event
  input  wire logic        section_parity_err_i,
  input  wire logic        line_parity_err_i,
  input  wire logic        path_parity_err_i,
  input  wire logic        line_remote_err_i,
  input  wire logic        path_remote_err_i,
  // Alarms
  input  wire logic        optical_loss_input_i,
  input  wire logic        line_rdi_req_i,
  input  wire logic        path_rdi_req_i,
  output logic             signal_loss_o,
  output logic             line_rdi_tx_o,
  output logic             path_rdi_tx_o,
  output logic             counter_overflow_irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [SEPC_NCNT-1:0][LONG_W-1:0] cnt;
    logic [SEPC_NCNT-1:0][LONG_W-1:0] hold;
    logic [SEPC_NCNT-1:0][1:0]        ptr;
    logic [SEPC_NCNT-1:0]             ovf;
    logic                             ovf_cause;
    logic [2:0]                       af_mask;
    logic [7:0]                       pri_mask;
    logic                             sig_loss;
    logic                             opt_lvl;
    logic                             line_rdi_tx;
    logic                             path_rdi_tx;
    logic                             aw_got;
    logic [5:0]                       aw_idx;
    logic                             w_got;
    logic [7:0]                       wdata;
    logic                             wlane;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             rvalid;
    logic [7:0]                       rdata;
    logic [1:0]                       rresp;
  } sepc_state_type;

  sepc_state_type st_r;
  sepc_state_type st_nxt;
  logic [SEPC_NCNT-1:0] ev;
  logic [SEPC_NCNT-1:0] clr_go;
  logic [SEPC_NCNT-1:0] ovf_set;
  logic                 sample_go;
  logic                 wr_go;
  logic                 rd_go;
  logic [5:0]           ar_idx;
  assign ev = {path_remote_err_i, line_remote_err_i, path_parity_err_i,
               line_parity_err_i, section_parity_err_i};
  assign ar_idx = s_axi_araddr_i[7:2];

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_long(input int i);
    return (i == SEPC_C_LINE) || (i == SEPC_C_LREI);
  endfunction
  function automatic logic [LONG_W-1:0] cnt_max(input int i);
    logic [LONG_W-1:0] m;
    m = '1;
    return is_long(i) ? m : m >> (LONG_W - SHORT_W);
  endfunction
  // Two-part window toggles, three-part steps 0,1,2,0
  function automatic logic [1:0] ptr_step(input logic [1:0] p,
                                          input logic long_w);
    if (long_w) begin
      return (p == 2'h2) ? 2'h0 : p + 2'h1;
    end
    return {1'b0, ~p[0]};
  endfunction
  function automatic logic [7:0] win_byte(input logic [LONG_W-1:0] h,
                                          input logic [1:0] p);
    case (p)
      2'h0:    return h[7:0];
      2'h1:    return h[15:8];
      default: return {4'h0, h[19:16]};
    endcase
  endfunction

  function automatic int win_slot(input logic [5:0] idx);
    int s;
    s = -1;
    if (idx == SEPC_IDX_WIN_SECT) begin
      s = SEPC_C_SECT;
    end else if (idx == SEPC_IDX_WIN_LINE) begin
      s = SEPC_C_LINE;
    end else if (idx == SEPC_IDX_WIN_PATH) begin
      s = SEPC_C_PATH;
    end else if (idx == SEPC_IDX_WIN_LREI) begin
      s = SEPC_C_LREI;
    end else if (idx == SEPC_IDX_WIN_PREI) begin
      s = SEPC_C_PREI;
    end
    return s;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    int ws;
    logic [SEPC_NCNT-1:0] ovf_rdclr;
    logic                 cause_rdclr;
    logic                 wr_ok;
    logic [LONG_W-1:0]    inc;
    ws = -1;
    ovf_rdclr = '0;
    cause_rdclr = 1'b0;
    wr_ok = 1'b0;
    inc = '0;
    st_nxt = st_r;
    sample_go = 1'b0;
    clr_go = '0;
    ovf_set = '0;

    // Write channel capture, either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr_i[7:2];
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata_i[7:0];
      st_nxt.wlane = s_axi_wstrb_i[0];
    end
    wr_go = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      if (st_r.aw_idx == SEPC_IDX_AF_MASK) begin
        wr_ok = 1'b1;
        if (st_r.wlane) begin
          st_nxt.af_mask = st_r.wdata[2:0];
        end
      end else if (st_r.aw_idx == SEPC_IDX_PRI_MASK) begin
        wr_ok = 1'b1;
        if (st_r.wlane) begin
          st_nxt.pri_mask = st_r.wdata;
        end
      end else if (st_r.aw_idx == SEPC_IDX_SAMPLE) begin
        wr_ok = 1'b1;
        sample_go = st_r.wlane && st_r.wdata[SEPC_TRIG_BIT];
      end else if (st_r.aw_idx == SEPC_IDX_CLEAR) begin
        wr_ok = 1'b1;
        if (st_r.wlane) begin
          clr_go = st_r.wdata[SEPC_NCNT-1:0];
        end
      end else if ((st_r.aw_idx == SEPC_IDX_PRI_CAUSE) ||
                   (st_r.aw_idx == SEPC_IDX_RD_PTR) ||
                   (st_r.aw_idx == SEPC_IDX_OVF_FLAGS) ||
                   (win_slot(st_r.aw_idx) >= 0)) begin
        wr_ok = 1'b1;
      end
      st_nxt.bresp = wr_ok ? SEPC_RESP_OKAY : SEPC_RESP_SLVERR;
    end
    if (st_r.bvalid && s_axi_bready_i) begin
      st_nxt.bvalid = 1'b0;
    end

    // Read: answer registered, side effects at the address handshake
    rd_go = s_axi_arvalid_i && s_axi_arready_o;
    if (st_r.rvalid && s_axi_rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = SEPC_RESP_OKAY;
      st_nxt.rdata = 8'h00;
      ws = win_slot(ar_idx);
      if (ws >= 0) begin
        st_nxt.rdata = win_byte(st_r.hold[ws], st_r.ptr[ws]);
        st_nxt.ptr[ws] = ptr_step(st_r.ptr[ws], is_long(ws));
      end else if (ar_idx == SEPC_IDX_AF_MASK) begin
        st_nxt.rdata = {SEPC_AF_UPPER, st_r.af_mask};
      end else if (ar_idx == SEPC_IDX_PRI_MASK) begin
        st_nxt.rdata = st_r.pri_mask;
      end else if (ar_idx == SEPC_IDX_PRI_CAUSE) begin
        st_nxt.rdata[SEPC_PIC_OPT_BIT] = st_r.opt_lvl;
        st_nxt.rdata[SEPC_PIC_SIG_LOSS_BIT] = st_r.sig_loss;
        st_nxt.rdata[SEPC_PIC_OVF_BIT] = st_r.ovf_cause;
        cause_rdclr = 1'b1;
      end else if (ar_idx == SEPC_IDX_RD_PTR) begin
        st_nxt.rdata = {1'b0, st_r.ptr[SEPC_C_PREI][0],
                        st_r.ptr[SEPC_C_LREI], st_r.ptr[SEPC_C_PATH][0],
                        st_r.ptr[SEPC_C_LINE], st_r.ptr[SEPC_C_SECT][0]};
      end else if (ar_idx == SEPC_IDX_OVF_FLAGS) begin
        st_nxt.rdata = {3'h0, st_r.ovf};
        ovf_rdclr = '1;
      end else if ((ar_idx == SEPC_IDX_SAMPLE) ||
                   (ar_idx == SEPC_IDX_CLEAR)) begin
        st_nxt.rdata = 8'h00;
      end else begin
        st_nxt.rresp = SEPC_RESP_SLVERR;
      end
    end

    // Live counters; an event in a sample or clear cycle counts as one
    for (int i = 0; i < SEPC_NCNT; i++) begin
      inc = (st_r.cnt[i] + LONG_W'(1)) & cnt_max(i);
      if (sample_go) begin
        st_nxt.hold[i] = st_r.cnt[i];
      end
      if (sample_go || clr_go[i]) begin
        st_nxt.cnt[i] = LONG_W'(ev[i]);
      end else if (ev[i]) begin
        st_nxt.cnt[i] = inc;
        ovf_set[i] = (inc == cnt_max(i));
      end
    end
    // Set wins over clear-on-read
    st_nxt.ovf = (st_r.ovf & ~ovf_rdclr) | ovf_set;
    st_nxt.ovf_cause = (st_r.ovf_cause & ~cause_rdclr) | (|ovf_set);

    // Alarm outputs
    st_nxt.opt_lvl = optical_loss_input_i;
    st_nxt.sig_loss = optical_loss_input_i &&
                      !st_r.af_mask[SEPC_AF_OPT_BIT];
    st_nxt.line_rdi_tx = line_rdi_req_i &&
                         !st_r.af_mask[SEPC_AF_LINE_RDI_BIT];
    st_nxt.path_rdi_tx = path_rdi_req_i &&
                         !st_r.af_mask[SEPC_AF_PATH_RDI_BIT];
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.af_mask <= SEPC_AF_MASK_RST;
      st_r.pri_mask <= SEPC_PRI_MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready_o = !st_r.aw_got && !st_r.bvalid;
  assign s_axi_wready_o  = !st_r.w_got && !st_r.bvalid;
  assign s_axi_bvalid_o  = st_r.bvalid;
  assign s_axi_bresp_o   = st_r.bresp;
  assign s_axi_arready_o = !st_r.rvalid;
  assign s_axi_rvalid_o  = st_r.rvalid;
  assign s_axi_rresp_o   = st_r.rresp;
  assign s_axi_rdata_o   = {24'h00_0000, st_r.rdata};
  assign signal_loss_o   = st_r.sig_loss;
  assign line_rdi_tx_o   = st_r.line_rdi_tx;
  assign path_rdi_tx_o   = st_r.path_rdi_tx;
  assign counter_overflow_irq_o = st_r.ovf_cause &&
                                  !st_r.pri_mask[SEPC_PIC_OVF_BIT];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_af_mask_upper: assert property (
    rd_go && (ar_idx == SEPC_IDX_AF_MASK) |=> st_r.rdata[7:3] == 5'h1f)
    else $error("alarm mask upper bits not one");
  a_loss_follows_pin: assert property (
    signal_loss_o == ($past(optical_loss_input_i) &&
                      !$past(st_r.af_mask[SEPC_AF_OPT_BIT])))
    else $error("signal loss does not follow pin and mask");
  a_pin_mirrored: assert property (
    st_r.opt_lvl == $past(optical_loss_input_i))
    else $error("optical pin not mirrored");
  a_line_rdi_gate: assert property (
    line_rdi_tx_o == ($past(line_rdi_req_i) &&
                      !$past(st_r.af_mask[SEPC_AF_LINE_RDI_BIT])))
    else $error("line rdi gating wrong");
  a_path_rdi_gate: assert property (
    path_rdi_tx_o == ($past(path_rdi_req_i) &&
                      !$past(st_r.af_mask[SEPC_AF_PATH_RDI_BIT])))
    else $error("path rdi gating wrong");
  a_ptr_two_toggle: assert property (
    rd_go && (ar_idx == SEPC_IDX_WIN_SECT) |=>
      st_r.ptr[SEPC_C_SECT][0] != $past(st_r.ptr[SEPC_C_SECT][0]))
    else $error("two-part pointer did not toggle");
  a_ptr_three_range: assert property (
    st_r.ptr[SEPC_C_LINE] != 2'h3 && st_r.ptr[SEPC_C_LREI] != 2'h3)
    else $error("three-part pointer out of range");
  a_sample_capture: assert property (
    sample_go |=> st_r.hold[SEPC_C_LINE] == $past(st_r.cnt[SEPC_C_LINE]))
    else $error("sample did not capture counter");
  a_hold_stable: assert property (
    !sample_go |=> $stable(st_r.hold))
    else $error("hold changed without sample");
  a_sample_zero: assert property (
    sample_go |=> st_r.cnt[SEPC_C_SECT] <= LONG_W'(1))
    else $error("counter not zeroed on sample");
  a_ovf_flag_set: assert property (
    ovf_set[SEPC_C_PATH] |=> st_r.ovf[SEPC_C_PATH])
    else $error("overflow flag not set");
  a_ovf_cause: assert property (
    (|ovf_set) |=> st_r.ovf_cause)
    else $error("overflow cause not set");
  a_wrap_zero: assert property (
    ev[SEPC_C_SECT] && !sample_go && !clr_go[SEPC_C_SECT] &&
    st_r.cnt[SEPC_C_SECT] == cnt_max(SEPC_C_SECT)
    |=> st_r.cnt[SEPC_C_SECT] == '0)
    else $error("counter did not wrap");
  a_irq_masked: assert property (
    st_r.pri_mask[SEPC_PIC_OVF_BIT] |-> !counter_overflow_irq_o)
    else $error("masked overflow raised request");

  c_sample: cover property (sample_go ##[1:20] rd_go);
  c_overflow: cover property (|ovf_set);
  c_three_reads: cover property (
    st_r.ptr[SEPC_C_LINE] == 2'h2 ##[1:50] st_r.ptr[SEPC_C_LINE] == 2'h0);

endmodule

// >>> logic/sepc_pkg.sv
package sepc_pkg;

  // ****************************************************************
  // Counter slots
  // ****************************************************************
  localparam int SEPC_NCNT    = 5;
  localparam int SEPC_C_SECT  = 0;
  localparam int SEPC_C_LINE  = 1;
  localparam int SEPC_C_PATH  = 2;
  localparam int SEPC_C_LREI  = 3;
  localparam int SEPC_C_PREI  = 4;

  // ****************************************************************
  // Register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [5:0] SEPC_IDX_PRI_CAUSE  = 6'h06;
  localparam logic [5:0] SEPC_IDX_PRI_MASK   = 6'h07;
  localparam logic [5:0] SEPC_IDX_AF_MASK    = 6'h0c;
  localparam logic [5:0] SEPC_IDX_WIN_SECT   = 6'h0d;
  localparam logic [5:0] SEPC_IDX_WIN_LINE   = 6'h0e;
  localparam logic [5:0] SEPC_IDX_WIN_PATH   = 6'h0f;
  localparam logic [5:0] SEPC_IDX_WIN_LREI   = 6'h10;
  localparam logic [5:0] SEPC_IDX_WIN_PREI   = 6'h11;
  localparam logic [5:0] SEPC_IDX_RD_PTR     = 6'h19;
  localparam logic [5:0] SEPC_IDX_SAMPLE     = 6'h1b;
  localparam logic [5:0] SEPC_IDX_CLEAR      = 6'h1c;
  localparam logic [5:0] SEPC_IDX_OVF_FLAGS  = 6'h20;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SEPC_AF_OPT_BIT       = 2;
  localparam int SEPC_AF_LINE_RDI_BIT  = 1;
  localparam int SEPC_AF_PATH_RDI_BIT  = 0;
  localparam int SEPC_PIC_OPT_BIT      = 6;
  localparam int SEPC_PIC_SIG_LOSS_BIT = 5;
  localparam int SEPC_PIC_OVF_BIT      = 1;
  localparam int SEPC_TRIG_BIT         = 0;
  localparam logic [2:0] SEPC_AF_MASK_RST  = 3'h7;
  localparam logic [4:0] SEPC_AF_UPPER     = 5'h1f;
  localparam logic [7:0] SEPC_PRI_MASK_RST = 8'hff;

  // ****************************************************************
  // AXI responses
  // ****************************************************************
  localparam logic [1:0] SEPC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SEPC_RESP_SLVERR = 2'h2;

endpackage

// >>> bench/sonet_error_perf_counters_tb_top.sv
`timescale 1ns/1ps
module sonet_error_perf_counters_tb_top import sepc_pkg::*;;
  logic        clk_i;
  logic        sys_rst_i;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [4:0]  ev;
  logic        opt_pin;
  logic        line_rdi_req;
  logic        path_rdi_req;
  logic        sig_loss;
  logic        line_rdi_tx;
  logic        path_rdi_tx;
  logic        ovf_irq;
  int          n_mismatch;
  int          cmp_count;

  // ********
  // Design under test
  // ********
  sepc_counters i_sepc_counters (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .section_parity_err_i(ev[0]), .line_parity_err_i(ev[1]),
    .path_parity_err_i(ev[2]), .line_remote_err_i(ev[3]),
    .path_remote_err_i(ev[4]), .optical_loss_input_i(opt_pin),
    .line_rdi_req_i(line_rdi_req), .path_rdi_req_i(path_rdi_req),
    .signal_loss_o(sig_loss), .line_rdi_tx_o(line_rdi_tx),
    .path_rdi_tx_o(path_rdi_tx), .counter_overflow_irq_o(ovf_irq)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ********
  // Bus and compare tasks
  // ********
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t output %b expected %b", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_mismatch++;
    $display("ERROR %0t bus answer never came", $time);
    test_done();
  endtask

  // Every driving task starts on a fresh edge, so no signal is driven twice
  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = SEPC_RESP_OKAY);
    logic aw_p;
    logic w_p;
    int   k;
    @(posedge clk_i);
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_i);
      if (!aw_p && !w_p && bvalid) break;
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    if (k == 64) hang();
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp,
                    input logic [1:0] er = SEPC_RESP_OKAY);
    logic ar_p;
    int   k;
    @(posedge clk_i);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    ar_p = 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk_i);
      if (!ar_p && rvalid) break;
      if (ar_p && arready) begin
        ar_p = 1'b0;
        arvalid <= 1'b0;
      end
    end
    if (k == 64) hang();
    chk(rdata, {24'h00_0000, exp});
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask

  // Whole window, low part first; leaves its pointer back at zero
  task automatic rd_win(input int i, input logic [19:0] v);
    logic [5:0] a;
    a = SEPC_IDX_WIN_SECT + 6'(i);
    rd(a, v[7:0]);
    rd(a, v[15:8]);
    if (i == 1 || i == 3) rd(a, {4'h0, v[19:16]});
  endtask

  task automatic pulse(input logic [4:0] m, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      ev <= m;
    end
    @(posedge clk_i);
    ev <= 5'h00;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic sc_reset();
    rd(SEPC_IDX_AF_MASK, 8'hff);
    rd(SEPC_IDX_PRI_MASK, 8'hff);
    rd(SEPC_IDX_RD_PTR, 8'h00);
    rd(SEPC_IDX_OVF_FLAGS, 8'h00);
  endtask

  task automatic sc_alarm();
    wr(SEPC_IDX_AF_MASK, 8'h00);
    rd(SEPC_IDX_AF_MASK, 8'hf8);
    @(posedge clk_i);
    opt_pin  <= 1'b1;
    line_rdi_req <= 1'b1;
    path_rdi_req <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(sig_loss, 1'b1);
    chk_bit(line_rdi_tx, 1'b1);
    chk_bit(path_rdi_tx, 1'b1);
    rd(SEPC_IDX_PRI_CAUSE, 8'h60);
    wr(SEPC_IDX_AF_MASK, 8'h07);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk_bit(sig_loss, 1'b0);
    chk_bit(line_rdi_tx, 1'b0);
    chk_bit(path_rdi_tx, 1'b0);
    rd(SEPC_IDX_PRI_CAUSE, 8'h40);
    @(posedge clk_i);
    opt_pin <= 1'b0;
  endtask

  // Low bytes of all windows, then middle, then top parts
  task automatic sc_windows();
    for (int i = 0; i < 5; i++) pulse(5'(1 << i), 3 + 2 * i);
    wr(SEPC_IDX_SAMPLE, 8'h01);
    for (int i = 0; i < 5; i++)
      rd(SEPC_IDX_WIN_SECT + 6'(i), 8'(3 + 2 * i));
    rd(SEPC_IDX_RD_PTR, 8'h5b);
    for (int i = 0; i < 5; i++) rd(SEPC_IDX_WIN_SECT + 6'(i), 8'h00);
    rd(SEPC_IDX_RD_PTR, 8'h24);
    rd(SEPC_IDX_WIN_LINE, 8'h00);
    rd(SEPC_IDX_WIN_LREI, 8'h00);
    rd(SEPC_IDX_RD_PTR, 8'h00);
    pulse(5'h1f, 2);
    rd_win(0, 20'h0_0003);
    wr(SEPC_IDX_SAMPLE, 8'h01);
    for (int i = 0; i < 5; i++) rd_win(i, 20'h0_0002);
    rd(SEPC_IDX_SAMPLE, 8'h00);
  endtask

  task automatic sc_clear();
    for (int i = 0; i < 5; i++) begin
      pulse(5'h1f, 2);
      wr(SEPC_IDX_CLEAR, 8'(1 << i));
      wr(SEPC_IDX_SAMPLE, 8'h01);
      rd_win(i, 20'h0_0000);
    end
    rd(SEPC_IDX_CLEAR, 8'h00);
  endtask

  // Long enough for the short counters to reach all ones and wrap
  task automatic sc_overflow();
    wr(SEPC_IDX_PRI_MASK, 8'hfd);
    pulse(5'h1f, 65534);
    @(negedge clk_i);
    chk_bit(ovf_irq, 1'b0);
    pulse(5'h1f, 1);
    @(negedge clk_i);
    chk_bit(ovf_irq, 1'b1);
    wr(SEPC_IDX_PRI_MASK, 8'hff);
    @(negedge clk_i);
    chk_bit(ovf_irq, 1'b0);
    rd(SEPC_IDX_PRI_CAUSE, 8'h02);
    rd(SEPC_IDX_PRI_CAUSE, 8'h00);
    rd(SEPC_IDX_OVF_FLAGS, 8'h15);
    rd(SEPC_IDX_OVF_FLAGS, 8'h00);
    pulse(5'h1f, 308);
    wr(SEPC_IDX_SAMPLE, 8'h01);
    for (int i = 0; i < 5; i++)
      rd_win(i, (i == 1 || i == 3) ? 20'h1_0133 : 20'h0_0133);
  endtask

  task automatic sc_bus();
    wr(6'h3f, 8'hff, SEPC_RESP_SLVERR);
    rd(6'h3f, 8'h00, SEPC_RESP_SLVERR);
    wr(SEPC_IDX_RD_PTR, 8'hff);
    rd(SEPC_IDX_RD_PTR, 8'h00);
    wr(SEPC_IDX_AF_MASK, 8'h00);
    wr(SEPC_IDX_AF_MASK, 8'hff);
    rd(SEPC_IDX_AF_MASK, 8'hff);
    // Lane 0 strobe low: the write must leave the mask alone
    @(posedge clk_i);
    wstrb <= 4'h0;
    wr(SEPC_IDX_AF_MASK, 8'h00);
    rd(SEPC_IDX_AF_MASK, 8'hff);
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    n_mismatch = 0;
    cmp_count  = 0;
    sys_rst_i  = 1'b1;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0000_0000;
    wstrb   = 4'h1;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    ev      = 5'h00;
    opt_pin = 1'b0;
    line_rdi_req = 1'b0;
    path_rdi_req = 1'b0;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    sc_reset();
    sc_alarm();
    sc_windows();
    sc_clear();
    sc_overflow();
    sc_bus();
    test_done();
  end
endmodule
